// [hdl/wdog_pkg.sv]
// register map, field layout, reset values and enumerations of the watchdog
// assumes a 32-bit apb slave at word-aligned offsets
package wdog_pkg;
    localparam logic [11:0] OFS_CTRL    = 12'h000;
    localparam logic [11:0] OFS_PERIOD  = 12'h004;
    localparam logic [11:0] OFS_WINDOW  = 12'h008;
    localparam logic [11:0] OFS_SERVICE = 12'h00c;
    localparam logic [11:0] OFS_COUNT   = 12'h010;
    localparam logic [11:0] OFS_STATUS  = 12'h014;
    localparam logic [11:0] OFS_INT_EN  = 12'h018;
    localparam logic [11:0] OFS_INT_CLR = 12'h01c;

    // ctrl fields
    localparam int CTRL_EN      = 0;
    localparam int CTRL_WIN     = 1;
    localparam int CTRL_LPSTOP  = 2;
    localparam int CTRL_SOFTLK  = 3;
    localparam int CTRL_HARDLK  = 4;
    localparam int CTRL_ACT_LO  = 5;
    localparam int CTRL_ACT_HI  = 6;
    localparam int CTRL_CLK_LO  = 7;
    localparam int CTRL_CLK_HI  = 8;
    localparam int CTRL_W       = 9;
    localparam logic [8:0] CTRL_RST = 9'h001;

    // status fields
    localparam int ST_TIMEOUT   = 0;
    localparam int ST_EARLY     = 1;
    localparam int ST_W         = 2;

    localparam logic [31:0] PERIOD_RST = 32'h0001_f400;
    localparam logic [31:0] WINDOW_RST = 32'h0000_0000;
    localparam logic [31:0] KEY_A      = 32'h0000_a602;
    localparam logic [31:0] KEY_B      = 32'h0000_b480;

    typedef enum logic [1:0] {
        ACT_RESET,
        ACT_IRQ,
        ACT_IRQ_RESET
    } action_t;

    typedef enum logic [1:0] {
        CLK_SYS,
        CLK_XTAL,
        CLK_RC128K
    } clk_src_t;
endpackage

// [hdl/wdog_tick_sel.sv]
// one-cycle counting enable from the selected clock source
// assumes xtal and rc tick inputs are one-cycle strobes synchronous to clk_i
`timescale 1ns/1ps
module wdog_tick_sel (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic [1:0] src_i,
    input  wire logic       xtal_tick_i,
    input  wire logic       rc_tick_i,
    output logic            tick_o
);
    logic next_tick;

    always_comb begin
        case (src_i)
            wdog_pkg::CLK_SYS:    next_tick = 1'b1;
            wdog_pkg::CLK_XTAL:   next_tick = xtal_tick_i;
            wdog_pkg::CLK_RC128K: next_tick = rc_tick_i;
            default:              next_tick = rc_tick_i;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= next_tick;
        end
    end
endmodule

// [hdl/wdog_top.sv]
// windowed software watchdog with apb register access
// assumes apb master on clk_i; tick strobes and low_power_i synchronous to clk_i
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module wdog_top (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        xtal_tick_i,
    input  wire logic        rc_tick_i,
    input  wire logic        low_power_i,
    output logic             irq_o,
    output logic             reset_req_o
);
    logic [wdog_pkg::CTRL_W-1:0] ctrl;
    logic [wdog_pkg::CTRL_W-1:0] next_ctrl;
    logic [31:0]                 period;
    logic [31:0]                 next_period;
    logic [31:0]                 window;
    logic [31:0]                 next_window;
    logic [31:0]                 count;
    logic [31:0]                 next_count;
    logic                        key_half;
    logic                        next_key_half;
    logic                        armed;
    logic                        next_armed;
    logic [wdog_pkg::ST_W-1:0]   status;
    logic [wdog_pkg::ST_W-1:0]   next_status;
    logic [wdog_pkg::ST_W-1:0]   int_en;
    logic [wdog_pkg::ST_W-1:0]   next_int_en;
    logic                        next_irq;
    logic                        next_reset_req;
    logic [31:0]                 next_prdata;
    logic                        next_pready;
    logic                        next_pslverr;

    logic                        tick;
    logic                        setup;
    logic                        wr;
    logic                        locked;
    logic                        mapped;
    logic                        serviced;
    logic                        early;
    logic                        expire;
    logic                        fail;
    logic [1:0]                  action;

    wdog_tick_sel u_tick (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .src_i       (ctrl[wdog_pkg::CTRL_CLK_HI:wdog_pkg::CTRL_CLK_LO]),
        .xtal_tick_i (xtal_tick_i),
        .rc_tick_i   (rc_tick_i),
        .tick_o      (tick)
    );

    // apb decode: no wait state, answer in first access cycle
    assign setup  = psel_i && !penable_i;
    assign wr     = psel_i && penable_i && pready_o && pwrite_i;
    assign locked = ctrl[wdog_pkg::CTRL_SOFTLK] || ctrl[wdog_pkg::CTRL_HARDLK];
    assign action = ctrl[wdog_pkg::CTRL_ACT_HI:wdog_pkg::CTRL_ACT_LO];

    always_comb begin
        case (paddr_i)
            wdog_pkg::OFS_CTRL,
            wdog_pkg::OFS_PERIOD,
            wdog_pkg::OFS_WINDOW,
            wdog_pkg::OFS_SERVICE,
            wdog_pkg::OFS_COUNT,
            wdog_pkg::OFS_STATUS,
            wdog_pkg::OFS_INT_EN,
            wdog_pkg::OFS_INT_CLR: mapped = 1'b1;
            default:               mapped = 1'b0;
        endcase
    end

    // key sequence: first key then second key
    always_comb begin
        next_key_half = key_half;
        serviced      = 1'b0;
        if (wr && paddr_i == wdog_pkg::OFS_SERVICE) begin
            if (pwdata_i == wdog_pkg::KEY_A) begin
                next_key_half = 1'b1;
            end else if (pwdata_i == wdog_pkg::KEY_B && key_half) begin
                next_key_half = 1'b0;
                serviced      = 1'b1;
            end else begin
                next_key_half = 1'b0;
            end
        end
    end

    // windowed mode: service only accepted once count has fallen to window
    assign early  = serviced && ctrl[wdog_pkg::CTRL_WIN] && (count > window);
    assign expire = ctrl[wdog_pkg::CTRL_EN] && tick && (count == 32'h0000_0000)
                    && !(ctrl[wdog_pkg::CTRL_LPSTOP] && low_power_i);
    assign fail   = expire || early;

    // counter
    always_comb begin
        next_count = count;
        if (!ctrl[wdog_pkg::CTRL_EN]) begin
            next_count = period;
        end else if (serviced || fail) begin
            next_count = period;
        end else if (tick && !(ctrl[wdog_pkg::CTRL_LPSTOP] && low_power_i)) begin
            next_count = count - 32'h0000_0001;
        end
    end

    // response to a failure
    always_comb begin
        next_armed     = armed;
        next_reset_req = reset_req_o;
        next_status    = status;
        if (serviced && !early) begin
            next_armed = 1'b0;
        end
        if (wr && paddr_i == wdog_pkg::OFS_INT_CLR) begin
            next_status = status & ~pwdata_i[wdog_pkg::ST_W-1:0];
        end
        if (fail) begin
            next_status[wdog_pkg::ST_TIMEOUT] = 1'b1;
            if (early) begin
                next_status[wdog_pkg::ST_EARLY] = 1'b1;
            end
            case (action)
                wdog_pkg::ACT_RESET: next_reset_req = 1'b1;
                wdog_pkg::ACT_IRQ:   next_reset_req = 1'b0;
                wdog_pkg::ACT_IRQ_RESET: begin
                    if (armed) begin
                        next_reset_req = 1'b1;
                    end
                    next_armed = 1'b1;
                end
                default: next_reset_req = 1'b1;
            endcase
        end
    end

    assign next_irq = |(next_status & int_en) && (action != wdog_pkg::ACT_RESET);

    // configuration registers behind the locks
    always_comb begin
        next_ctrl   = ctrl;
        next_period = period;
        next_window = window;
        next_int_en = int_en;
        if (wr && paddr_i == wdog_pkg::OFS_CTRL && !ctrl[wdog_pkg::CTRL_HARDLK]) begin
            if (ctrl[wdog_pkg::CTRL_SOFTLK]) begin
                next_ctrl[wdog_pkg::CTRL_SOFTLK] = pwdata_i[wdog_pkg::CTRL_SOFTLK];
            end else begin
                next_ctrl = pwdata_i[wdog_pkg::CTRL_W-1:0];
            end
        end
        if (wr && !locked) begin
            if (paddr_i == wdog_pkg::OFS_PERIOD) begin
                next_period = pwdata_i;
            end
            if (paddr_i == wdog_pkg::OFS_WINDOW) begin
                next_window = pwdata_i;
            end
            if (paddr_i == wdog_pkg::OFS_INT_EN) begin
                next_int_en = pwdata_i[wdog_pkg::ST_W-1:0];
            end
        end
    end

    // read data and answer
    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pready  = setup;
        next_pslverr = setup && !mapped;
        if (setup && !pwrite_i) begin
            case (paddr_i)
                wdog_pkg::OFS_CTRL:   next_prdata = 32'(ctrl);
                wdog_pkg::OFS_PERIOD: next_prdata = period;
                wdog_pkg::OFS_WINDOW: next_prdata = window;
                wdog_pkg::OFS_COUNT:  next_prdata = count;
                wdog_pkg::OFS_STATUS: next_prdata = 32'(status);
                wdog_pkg::OFS_INT_EN: next_prdata = 32'(int_en);
                default:              next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl        <= wdog_pkg::CTRL_RST;
            period      <= wdog_pkg::PERIOD_RST;
            window      <= wdog_pkg::WINDOW_RST;
            count       <= wdog_pkg::PERIOD_RST;
            key_half    <= 1'b0;
            armed       <= 1'b0;
            status      <= '0;
            int_en      <= '0;
            irq_o       <= 1'b0;
            reset_req_o <= 1'b0;
            prdata_o    <= 32'h0000_0000;
            pready_o    <= 1'b0;
            pslverr_o   <= 1'b0;
        end else begin
            ctrl        <= next_ctrl;
            period      <= next_period;
            window      <= next_window;
            count       <= next_count;
            key_half    <= next_key_half;
            armed       <= next_armed;
            status      <= next_status;
            int_en      <= next_int_en;
            irq_o       <= next_irq;
            reset_req_o <= next_reset_req;
            prdata_o    <= next_prdata;
            pready_o    <= next_pready;
            pslverr_o   <= next_pslverr;
        end
    end
endmodule

// [bench/wdog_top_sva.sv]
// port-level assertion checker for the watchdog top
// assumes binding to wdog_top, one clock domain, aligned apb addresses
`timescale 1ns/1ps
module wdog_top_chk (
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        xtal_tick_i,
    input wire logic        rc_tick_i,
    input wire logic        low_power_i,
    input wire logic        irq_o,
    input wire logic        reset_req_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wire logic acc_wr = psel_i && penable_i && pwrite_i;
    sequence setup_s;
        psel_i && !penable_i;
    endsequence
    chk_ready_setup: assert property (setup_s |=> pready_o)
        else $error("no ready after setup");
    chk_ready_cause: assert property (pready_o |-> $past(psel_i && !penable_i))
        else $error("ready without setup");
    chk_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    chk_rdata_quiet: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
        else $error("read data outside access");
    chk_slverr_map: assert property (setup_s |=> pslverr_o ==
        ($past(paddr_i) > 12'h01c || $past(paddr_i[1:0]) != 2'b00))
        else $error("error response wrong");
    chk_reset_sticky: assert property (reset_req_o |=> reset_req_o)
        else $error("reset request dropped");
    chk_quiet_start: assert property (!$past(rstn_i) |-> !irq_o && !reset_req_o)
        else $error("output active after reset");
    chk_irq_fall: assert property ($fell(irq_o) |-> $past(acc_wr) || $past(acc_wr, 2))
        else $error("interrupt fell without write");
endmodule

bind wdog_top wdog_top_chk u_wdog_top_chk (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .xtal_tick_i(xtal_tick_i),
    .rc_tick_i(rc_tick_i), .low_power_i(low_power_i), .irq_o(irq_o), .reset_req_o(reset_req_o));

// [bench/testbench.sv]
// directed apb bench for the watchdog top
// assumes wdog_pkg, wdog_top and the checker compiled before it
`timescale 1ns/1ps
module testbench;
    logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i, err, pready_o, pslverr_o;
    logic        xtal_tick_i, rc_tick_i, low_power_i, irq_o, reset_req_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, d, c;
    int          n_mismatch, n_compared;
    wdog_top u_wdog_top (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .xtal_tick_i(xtal_tick_i), .rc_tick_i(rc_tick_i), .low_power_i(low_power_i),
        .irq_o(irq_o), .reset_req_o(reset_req_o));
    always #2.5 clk_i = ~clk_i;
    task automatic summarize;
        if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chkf(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: flag %b want %b", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= v;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        d = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        xfer(1'b1, a, v);
    endtask
    task automatic rd(input logic [11:0] a);
        xfer(1'b0, a, 32'h0000_0000);
    endtask
    task automatic svc;
        wr(wdog_pkg::OFS_SERVICE, wdog_pkg::KEY_A);
        wr(wdog_pkg::OFS_SERVICE, wdog_pkg::KEY_B);
    endtask
    task automatic await(input bit rq);
        repeat (400) if ((rq ? reset_req_o : irq_o) !== 1'b1) @(posedge clk_i);
    endtask
    task automatic reboot;
        rstn_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
    endtask
    initial begin
        #20000;
        n_mismatch++;
        summarize();
    end
    initial begin
        {clk_i, rstn_i, psel_i, penable_i, pwrite_i, xtal_tick_i, rc_tick_i, low_power_i} = '0;
        paddr_i = '0;
        pwdata_i = '0;
        n_mismatch = 0;
        n_compared = 0;
        reboot();
        rd(wdog_pkg::OFS_CTRL);
        chk(d, 32'h0000_0001);
        rd(wdog_pkg::OFS_PERIOD);
        chk(d, wdog_pkg::PERIOD_RST);
        rd(wdog_pkg::OFS_COUNT);
        c = d;
        rd(wdog_pkg::OFS_COUNT);
        chkf(d < c, 1'b1);
        rd(12'h020);
        chkf(err, 1'b1);
        wr(wdog_pkg::OFS_PERIOD, 32'h0000_0040);
        wr(wdog_pkg::OFS_CTRL, 32'h0000_0029);
        wr(wdog_pkg::OFS_PERIOD, 32'h0000_0080);
        rd(wdog_pkg::OFS_PERIOD);
        chk(d, 32'h0000_0040);
        wr(wdog_pkg::OFS_CTRL, 32'h0000_0021);
        wr(wdog_pkg::OFS_INT_EN, 32'h0000_0001);
        rd(wdog_pkg::OFS_CTRL);
        chk(d, 32'h0000_0021);
        svc();
        rd(wdog_pkg::OFS_COUNT);
        chkf(d > 32'h0000_0030 && d <= 32'h0000_0040, 1'b1);
        await(1'b0);
        chkf(irq_o, 1'b1);
        rd(wdog_pkg::OFS_STATUS);
        chk(d, 32'h0000_0001);
        wr(wdog_pkg::OFS_INT_EN, 32'h0000_0000);
        repeat (2) @(posedge clk_i);
        chkf(irq_o, 1'b0);
        wr(wdog_pkg::OFS_INT_CLR, 32'h0000_0003);
        wr(wdog_pkg::OFS_INT_EN, 32'h0000_0001);
        wr(wdog_pkg::OFS_CTRL, 32'h0000_0025);
        svc();
        low_power_i <= 1'b1;
        rd(wdog_pkg::OFS_COUNT);
        c = d;
        rd(wdog_pkg::OFS_COUNT);
        chk(d, c);
        wr(wdog_pkg::OFS_CTRL, 32'h0000_0021);
        rd(wdog_pkg::OFS_COUNT);
        c = d;
        rd(wdog_pkg::OFS_COUNT);
        chkf(d < c, 1'b1);
        low_power_i <= 1'b0;
        for (int s = 1; s < 3; s++) begin
            wr(wdog_pkg::OFS_CTRL, 32'h0000_0021 | (32'(s) << 7));
            svc();
            rd(wdog_pkg::OFS_COUNT);
            c = d;
            repeat (4) begin
                xtal_tick_i <= (s == 1);
                rc_tick_i   <= (s == 2);
                @(posedge clk_i);
                xtal_tick_i <= (s == 2);
                rc_tick_i   <= (s == 1);
                @(posedge clk_i);
            end
            xtal_tick_i <= 1'b0;
            rc_tick_i   <= 1'b0;
            repeat (3) @(posedge clk_i);
            rd(wdog_pkg::OFS_COUNT);
            chk(c - d, 32'h0000_0004);
        end
        wr(wdog_pkg::OFS_WINDOW, 32'h0000_0010);
        wr(wdog_pkg::OFS_CTRL, 32'h0000_0023);
        wr(wdog_pkg::OFS_INT_CLR, 32'h0000_0003);
        svc();
        rd(wdog_pkg::OFS_STATUS);
        chk(d, 32'h0000_0003);
        wr(wdog_pkg::OFS_INT_CLR, 32'h0000_0003);
        repeat (45) @(posedge clk_i);
        svc();
        rd(wdog_pkg::OFS_STATUS);
        chk(d, 32'h0000_0000);
        wr(wdog_pkg::OFS_CTRL, 32'h0000_0041);
        svc();
        await(1'b0);
        chkf(reset_req_o, 1'b0);
        await(1'b1);
        chkf(reset_req_o, 1'b1);
        reboot();
        wr(wdog_pkg::OFS_CTRL, 32'h0000_0011);
        wr(wdog_pkg::OFS_CTRL, 32'h0000_0021);
        wr(wdog_pkg::OFS_PERIOD, 32'h0000_0040);
        rd(wdog_pkg::OFS_CTRL);
        chk(d, 32'h0000_0011);
        rd(wdog_pkg::OFS_PERIOD);
        chk(d, wdog_pkg::PERIOD_RST);
        reboot();
        rd(wdog_pkg::OFS_CTRL);
        chk(d, 32'h0000_0001);
        wr(wdog_pkg::OFS_INT_EN, 32'h0000_0001);
        wr(wdog_pkg::OFS_PERIOD, 32'h0000_0020);
        svc();
        await(1'b1);
        chkf(reset_req_o, 1'b1);
        chkf(irq_o, 1'b0);
        rd(wdog_pkg::OFS_STATUS);
        chk(d, 32'h0000_0001);
        summarize();
    end
endmodule
